// File: logic/tls_defines.svh
// Offsets, field positions and reset values of the link status block
`ifndef TLS_DEFINES_SVH
`define TLS_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define TLS_OFF_STATUS 4'h0
`define TLS_OFF_CTRL 4'h4
`define TLS_OFF_IRQ_STAT 4'h8
`define TLS_OFF_IRQ_MASK 4'hC

// ****************************************
// Status register fields
// ****************************************
`define TLS_ST_LINK_STATUS_10M_BIT 2
`define TLS_ST_APS 3
`define TLS_ST_LINK_STATUS_10M_BIT_VALID 4
`define TLS_ST_ARA 8
`define TLS_ST_ANS_LO 12
`define TLS_ST_ANS_HI 14

// ****************************************
// Control register fields
// ****************************************
`define TLS_CT_PORT_SEL 0
`define TLS_CT_CLOSE_EN 1
`define TLS_CT_AN_EN 7
`define TLS_CT_SQUELCH_EN 8
`define TLS_CT_AUTOPOL_EN 13
`define TLS_CT_POL_PLUS 14
`define TLS_CTRL_RESET 32'h0000_2100

// ****************************************
// Event bits and descriptor flags
// ****************************************
`define TLS_EV_ARA 0
`define TLS_EV_FAIL 1
`define TLS_EV_PASS 2
`define TLS_EV_W 3
`define TLS_TD_LINK_FAIL 2
`define TLS_TD_NO_CARRIER 10
`define TLS_TD_LOSS_CARRIER 11
`define TLS_ANS_COMPLETE 3'h5
`define TLS_AXI_OKAY 2'h0
`define TLS_AXI_SLVERR 2'h2
`define TLS_ZERO32 32'h0000_0000

`endif

// File: logic/tls_pkg.sv
// Types shared by the link status block
package tls_pkg;

	// Link integrity state, Gray coded along fail -> one frame -> pass
	typedef enum logic [1:0] {
		TLS_LINK_FAIL = 2'h0,
		TLS_LINK_ONE_FRAME = 2'h1,
		TLS_LINK_PASS = 2'h3
	} tls_link_state_t;

	// Control settings as one carrier
	typedef struct packed {
		logic pol_plus;
		logic autopol_en;
		logic squelch_en;
		logic an_en;
		logic close_en;
		logic port_sel;
	} tls_ctrl_t;

	// Synchronised medium pins
	typedef struct packed {
		logic rx_data;
		logic pol_neg;
		logic link_lost;
		logic link_pulse_ok;
		logic aui_act;
	} tls_pins_t;

endpackage : tls_pkg

// File: logic/tls_link_status.sv
// 10 Mb/s link integrity, polarity and AUI activity status with AXI4-Lite registers
//
// Overview of operation
// R1: AUI activity sets flag; write one clears
// R2: Polarity bit: one positive, zero negative
// R3: Invert received bits on negative polarity
// R4: Link status bit: one fail, zero pass
// R5: Status valid only twisted-pair with squelch enabled
// R6: No transmit while twisted-pair link fails
// R7: Close queued descriptors with three fault flags
// R8: Pulses or two good frames restore pass
// R9: No frame delivered while twisted-pair link fails
// R10: With autonegotiation, valid only when complete
// R11: Three-bit arbitration field, 101 means complete
// R12: Reported link state never metastable
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "tls_defines.svh"

module tls_link_status
	import tls_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Medium pins, asynchronous
	input wire logic aui_rx_act_pin,
	input wire logic tp_link_pulse_ok_pin,
	input wire logic tp_link_lost_pin,
	input wire logic tp_pol_neg_pin,
	input wire logic tp_rx_data_pin,
	// Receive engine
	input wire logic rx_frame_end,
	input wire logic rx_frame_good,
	output logic rx_deliver,
	output logic rx_data,
	// Transmit engine
	input wire logic tx_req,
	output logic tx_start,
	output logic tx_close,
	output logic [31:0] tx_descriptor_status_word,
	// Autonegotiation arbiter
	input wire logic [2:0] an_arb_state,
	// Interrupt
	output logic irq
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	localparam int NPINS = 5;
	logic [NPINS-1:0] pin_raw;
	logic [NPINS-1:0] pin_meta;
	logic [NPINS-1:0] pin_sync;
	tls_pins_t pins;

	assign pin_raw = {tp_rx_data_pin, tp_pol_neg_pin, tp_link_lost_pin,
		tp_link_pulse_ok_pin, aui_rx_act_pin};

	genvar gi;
	generate
		for (gi = 0; gi < NPINS; gi++) begin : g_sync
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					pin_meta[gi] <= 1'b0;
					pin_sync[gi] <= 1'b0;
				end else begin
					pin_meta[gi] <= pin_raw[gi];
					pin_sync[gi] <= pin_meta[gi];
				end
			end
		end
	endgenerate

	assign pins = tls_pins_t'(pin_sync); // R12

	// ****************************************
	// Register state
	// ****************************************
	localparam logic [31:0] CTRL_RESET = `TLS_CTRL_RESET;
	tls_ctrl_t ctrl;
	tls_link_state_t link_state;
	tls_link_state_t next_link_state;
	logic ara_flag;
	logic [`TLS_EV_W-1:0] irq_stat;
	logic [`TLS_EV_W-1:0] irq_mask;
	logic [`TLS_EV_W-1:0] events;
	logic link_fail;
	logic tp_mode;
	logic tp_blocked;
	logic invert;
	logic link_status_10m_bit_valid;
	logic [31:0] status_word;

	// ****************************************
	// AXI4-Lite write channel
	// ****************************************
	logic aw_held;
	logic w_held;
	logic [3:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_fire;
	logic [31:0] wr_mask;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;
	assign wr_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= `TLS_ZERO32;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `TLS_AXI_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr[1:0] == 2'h0) ? `TLS_AXI_OKAY : `TLS_AXI_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	logic wr_ctrl;
	logic wr_status;
	logic wr_istat;
	logic wr_imask;
	assign wr_ctrl = wr_fire && aw_addr == `TLS_OFF_CTRL;
	assign wr_status = wr_fire && aw_addr == `TLS_OFF_STATUS;
	assign wr_istat = wr_fire && aw_addr == `TLS_OFF_IRQ_STAT;
	assign wr_imask = wr_fire && aw_addr == `TLS_OFF_IRQ_MASK;

	// ****************************************
	// Control and interrupt registers
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= '{pol_plus: CTRL_RESET[`TLS_CT_POL_PLUS],
				autopol_en: CTRL_RESET[`TLS_CT_AUTOPOL_EN],
				squelch_en: CTRL_RESET[`TLS_CT_SQUELCH_EN],
				an_en: CTRL_RESET[`TLS_CT_AN_EN],
				close_en: CTRL_RESET[`TLS_CT_CLOSE_EN],
				port_sel: CTRL_RESET[`TLS_CT_PORT_SEL]};
		end else if (wr_ctrl) begin
			ctrl <= '{pol_plus: w_data[`TLS_CT_POL_PLUS],
				autopol_en: w_data[`TLS_CT_AUTOPOL_EN],
				squelch_en: w_data[`TLS_CT_SQUELCH_EN],
				an_en: w_data[`TLS_CT_AN_EN],
				close_en: w_data[`TLS_CT_CLOSE_EN],
				port_sel: w_data[`TLS_CT_PORT_SEL]};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_mask <= '0;
		end else if (wr_imask && w_strb[0]) begin
			irq_mask <= w_data[`TLS_EV_W-1:0];
		end
	end

	// Set wins over write-one-to-clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat <= '0;
		end else begin
			irq_stat <= (irq_stat & ~((wr_istat && w_strb[0]) ?
				w_data[`TLS_EV_W-1:0] : '0)) | events;
		end
	end

	assign irq = |(irq_stat & irq_mask);

	// ****************************************
	// AUI activity flag
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ara_flag <= 1'b0;
		end else if (pins.aui_act) begin
			ara_flag <= 1'b1; // R1
		end else if (wr_status && wr_mask[`TLS_ST_ARA] && w_data[`TLS_ST_ARA]) begin
			ara_flag <= 1'b0; // R1
		end
	end

	// ****************************************
	// Link integrity test
	// ****************************************
	// Port select clear means twisted pair
	assign tp_mode = !ctrl.port_sel;
	assign link_fail = (link_state != TLS_LINK_PASS);
	assign tp_blocked = tp_mode && link_fail;

	always_comb begin
		next_link_state = link_state;
		case (link_state)
			TLS_LINK_PASS: begin
				if (pins.link_lost) begin
					next_link_state = TLS_LINK_FAIL;
				end
			end
			TLS_LINK_FAIL: begin
				if (pins.link_pulse_ok) begin
					next_link_state = TLS_LINK_PASS; // R8
				end else if (rx_frame_end && rx_frame_good) begin
					next_link_state = TLS_LINK_ONE_FRAME; // R8
				end
			end
			TLS_LINK_ONE_FRAME: begin
				// A bad frame breaks the consecutive pair
				if (pins.link_pulse_ok || (rx_frame_end && rx_frame_good)) begin
					next_link_state = TLS_LINK_PASS; // R8
				end else if (pins.link_lost || rx_frame_end) begin
					next_link_state = TLS_LINK_FAIL;
				end
			end
			default: begin
				next_link_state = TLS_LINK_FAIL;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			link_state <= TLS_LINK_FAIL;
		end else begin
			link_state <= next_link_state;
		end
	end

	assign events[`TLS_EV_ARA] = pins.aui_act && !ara_flag;
	assign events[`TLS_EV_FAIL] = link_state == TLS_LINK_PASS && next_link_state != TLS_LINK_PASS;
	assign events[`TLS_EV_PASS] = link_state != TLS_LINK_PASS && next_link_state == TLS_LINK_PASS;

	// ****************************************
	// Transmit gating and descriptor close
	// ****************************************
	assign tx_start = tx_req && !tp_blocked; // R6

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_close <= 1'b0;
			tx_descriptor_status_word <= `TLS_ZERO32;
		end else begin
			// One close per request pulse; the engine drops tx_req on tx_close
			tx_close <= tx_req && tp_blocked && ctrl.close_en && !tx_close; // R7
			if (tx_req && tp_blocked && ctrl.close_en && !tx_close) begin
				tx_descriptor_status_word <= `TLS_ZERO32;
				tx_descriptor_status_word[`TLS_TD_LINK_FAIL] <= 1'b1; // R7
				tx_descriptor_status_word[`TLS_TD_NO_CARRIER] <= 1'b1; // R7
				tx_descriptor_status_word[`TLS_TD_LOSS_CARRIER] <= 1'b1; // R7
			end
		end
	end

	// ****************************************
	// Receive gating and polarity
	// ****************************************
	// Autopolarity off: polarity plus forces the sense
	assign invert = ctrl.autopol_en ? pins.pol_neg : !ctrl.pol_plus; // R3

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_deliver <= 1'b0;
			rx_data <= 1'b0;
		end else begin
			// Frames that restore the link are swallowed too
			rx_deliver <= rx_frame_end && rx_frame_good && !tp_blocked; // R8 R9
			rx_data <= pins.rx_data ^ invert; // R3
		end
	end

	// ****************************************
	// Status word and read channel
	// ****************************************
	assign link_status_10m_bit_valid = tp_mode && ctrl.squelch_en &&
		(!ctrl.an_en || an_arb_state == `TLS_ANS_COMPLETE); // R5 R10

	always_comb begin
		status_word = `TLS_ZERO32;
		status_word[`TLS_ST_LINK_STATUS_10M_BIT] = link_fail; // R4
		status_word[`TLS_ST_APS] = !pins.pol_neg; // R2
		status_word[`TLS_ST_LINK_STATUS_10M_BIT_VALID] = link_status_10m_bit_valid; // R5
		status_word[`TLS_ST_ARA] = ara_flag;
		status_word[`TLS_ST_ANS_HI:`TLS_ST_ANS_LO] = an_arb_state; // R11
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= `TLS_ZERO32;
			s_axi_rresp <= `TLS_AXI_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `TLS_AXI_OKAY;
			case (s_axi_araddr)
				`TLS_OFF_STATUS: s_axi_rdata <= status_word; // R12
				`TLS_OFF_CTRL: begin
					s_axi_rdata <= `TLS_ZERO32;
					s_axi_rdata[`TLS_CT_PORT_SEL] <= ctrl.port_sel;
					s_axi_rdata[`TLS_CT_CLOSE_EN] <= ctrl.close_en;
					s_axi_rdata[`TLS_CT_AN_EN] <= ctrl.an_en;
					s_axi_rdata[`TLS_CT_SQUELCH_EN] <= ctrl.squelch_en;
					s_axi_rdata[`TLS_CT_AUTOPOL_EN] <= ctrl.autopol_en;
					s_axi_rdata[`TLS_CT_POL_PLUS] <= ctrl.pol_plus;
				end
				`TLS_OFF_IRQ_STAT: s_axi_rdata <= {{(32-`TLS_EV_W){1'b0}}, irq_stat};
				`TLS_OFF_IRQ_MASK: s_axi_rdata <= {{(32-`TLS_EV_W){1'b0}}, irq_mask};
				default: begin
					s_axi_rdata <= `TLS_ZERO32;
					s_axi_rresp <= `TLS_AXI_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_ARA_SET: assert property (pins.aui_act |=> ara_flag) // R1
		else $error("AUI activity did not set flag");
	AST_APS_BIT: assert property (status_word[`TLS_ST_APS] != pins.pol_neg) // R2
		else $error("Polarity bit wrong");
	AST_RX_INVERT: assert property (ctrl.autopol_en && $stable(ctrl) ##1 ctrl.autopol_en
		|-> rx_data == ($past(pins.rx_data) ^ $past(pins.pol_neg))) // R3
		else $error("Receive data not corrected for polarity");
	AST_LINK_STATUS_10M_BIT_STATE: assert property (status_word[`TLS_ST_LINK_STATUS_10M_BIT] == (link_state != TLS_LINK_PASS)) // R4
		else $error("Link status bit disagrees with state");
	AST_LINK_STATUS_10M_BIT_VALID: assert property (link_status_10m_bit_valid |-> tp_mode && ctrl.squelch_en) // R5
		else $error("Link status valid outside twisted pair");
	AST_NO_TX_FAIL: assert property (tp_mode && link_fail |-> !tx_start) // R6
		else $error("Transmit while link fails");
	AST_CLOSE_FLAGS: assert property (tx_close |-> tx_descriptor_status_word ==
		32'h0000_0C04) // R7
		else $error("Closed descriptor flags wrong");
	AST_TWO_FRAMES: assert property (link_state == TLS_LINK_FAIL && rx_frame_end &&
		rx_frame_good && !pins.link_pulse_ok ##1 rx_frame_end && rx_frame_good
		|=> link_state == TLS_LINK_PASS) // R8
		else $error("Two good frames did not pass the link");
	AST_NO_RX_FAIL: assert property (tp_mode && link_fail && rx_frame_end |=> !rx_deliver) // R9
		else $error("Frame delivered during link fail");
	AST_AN_VALID: assert property (ctrl.an_en && an_arb_state != `TLS_ANS_COMPLETE |-> !link_status_10m_bit_valid) // R10
		else $error("Link status valid before autonegotiation done");
	AST_ANS_FIELD: assert property (status_word[`TLS_ST_ANS_HI:`TLS_ST_ANS_LO] == an_arb_state) // R11
		else $error("Arbitration field not reported");
	AST_STATUS_READ: assert property (s_axi_arvalid && s_axi_arready &&
		s_axi_araddr == `TLS_OFF_STATUS |=> s_axi_rvalid &&
		s_axi_rdata[`TLS_ST_LINK_STATUS_10M_BIT] == $past(link_fail)) // R12
		else $error("Status read does not show link state");

	CV_PASS: cover property (link_state == TLS_LINK_FAIL ##[1:20] link_state == TLS_LINK_PASS);
	CV_CLOSE: cover property (tx_close);
	CV_IRQ: cover property (irq);

endmodule : tls_link_status

// File: verification/tls_medium_model.sv
// Twisted-pair and AUI medium model driving the block's line pins
`timescale 1ns/1ps

module tls_medium_model
	import tls_pkg::*;
(
	// Clock
	input wire logic aclk,
	// Line conditions requested by the bench
	input wire tls_pins_t want,
	// Pins toward the block
	output tls_pins_t pins
);
	// ****************************************
	// Line levels
	// ****************************************
	// A lost link carries no pulse stream, so both never show at once
	always_ff @(posedge aclk) begin
		pins.rx_data <= want.rx_data;
		pins.pol_neg <= want.pol_neg;
		pins.link_lost <= want.link_lost;
		pins.link_pulse_ok <= want.link_pulse_ok && !want.link_lost;
		pins.aui_act <= want.aui_act;
	end
endmodule : tls_medium_model

// File: verification/tls_link_status_bench.sv
// Self-checking bench of the link status block
`timescale 1ns/1ps
`include "tls_defines.svh"

module tls_link_status_bench;
	import tls_pkg::*;
	logic aclk = 0;
	logic aresetn = 0;
	logic [3:0] s_axi_awaddr = 4'h0;
	logic [3:0] s_axi_araddr = 4'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_rdata, tx_descriptor_status_word;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic rx_frame_end = 0, rx_frame_good = 0, tx_req = 0;
	logic tx_start, tx_close, rx_deliver, rx_data, irq;
	logic [2:0] an_arb_state = 3'h0;
	tls_pins_t md = '0;
	tls_pins_t pins;
	int mismatches = 0, cmp_count = 0, n_start = 0, n_close = 0, n_dlv = 0;

	always #12.5 aclk = ~aclk;

	tls_medium_model i_tls_medium_model (.aclk, .want(md), .pins);

	tls_link_status i_tls_link_status (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.aui_rx_act_pin(pins.aui_act), .tp_link_pulse_ok_pin(pins.link_pulse_ok),
		.tp_link_lost_pin(pins.link_lost), .tp_pol_neg_pin(pins.pol_neg),
		.tp_rx_data_pin(pins.rx_data), .rx_frame_end, .rx_frame_good, .rx_deliver,
		.rx_data, .tx_req, .tx_start, .tx_close, .tx_descriptor_status_word,
		.an_arb_state, .irq
	);

	// ****************************************
	// Pulse counters
	// ****************************************
	// The queue entry is gone once closed, so the request drops with it
	always @(posedge aclk) begin
		if (tx_start)
			n_start++;
		if (tx_close) begin
			n_close++;
			tx_req <= 0;
		end
		if (rx_deliver)
			n_dlv++;
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic tmo(input logic ok);
		if (!ok) begin
			mismatches++;
			$display("CHECK FAILED at %0t wait expired got 0 expected 1", $time);
			print_verdict();
		end
	endtask : tmo

	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
		int n;
		logic done;
		done = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (n = 0; n < 40 && !done; n++) begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 0;
			if (s_axi_wready)
				s_axi_wvalid <= 0;
			if (s_axi_bvalid) begin
				done = 1;
				s_axi_bready <= 0;
				chk(32'(s_axi_bresp), 32'(er));
			end
		end
		tmo(done);
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
		int n;
		logic done;
		done = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (n = 0; n < 40 && !done; n++) begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 0;
			if (s_axi_rvalid) begin
				done = 1;
				s_axi_rready <= 0;
				chk(s_axi_rdata, e);
				chk(32'(s_axi_rresp), 32'(er));
			end
		end
		tmo(done);
	endtask : rd

	task automatic frame(input logic good);
		@(posedge aclk);
		rx_frame_end <= 1;
		rx_frame_good <= good;
		@(posedge aclk);
		rx_frame_end <= 0;
	endtask : frame

	task automatic settle(input int k);
		repeat (k) @(posedge aclk);
	endtask : settle

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		settle(2);
		rd(`TLS_OFF_CTRL, 32'h0000_2100);
		rd(`TLS_OFF_STATUS, 32'h0000_001C);
		tx_req <= 1;
		settle(4);
		chk(32'(n_start), 32'h0000_0000);
		wr(`TLS_OFF_CTRL, 32'h0000_2102);
		settle(3);
		chk(32'(n_close), 32'h0000_0001);
		chk(tx_descriptor_status_word, 32'h0000_0C04);
		$display("link fail blocking test done");
		wr(`TLS_OFF_IRQ_STAT, 32'h0000_0007);
		wr(`TLS_OFF_IRQ_MASK, 32'h0000_0007);
		frame(1);
		frame(1);
		settle(2);
		rd(`TLS_OFF_STATUS, 32'h0000_0018);
		chk(32'(n_dlv), 32'h0000_0000);
		rd(`TLS_OFF_IRQ_STAT, 32'h0000_0004);
		chk(32'(irq), 32'h0000_0001);
		frame(1);
		settle(2);
		chk(32'(n_dlv), 32'h0000_0001);
		tx_req <= 1;
		settle(2);
		tx_req <= 0;
		chk(32'(n_start != 0), 32'h0000_0001);
		$display("frame pair test done");
		md.link_lost <= 1;
		settle(4);
		md.link_lost <= 0;
		rd(`TLS_OFF_STATUS, 32'h0000_001C);
		rd(`TLS_OFF_IRQ_STAT, 32'h0000_0006);
		wr(`TLS_OFF_IRQ_STAT, 32'h0000_0004);
		wr(`TLS_OFF_IRQ_MASK, 32'h0000_0004);
		chk(32'(irq), 32'h0000_0000);
		wr(`TLS_OFF_IRQ_MASK, 32'h0000_0002);
		chk(32'(irq), 32'h0000_0001);
		wr(`TLS_OFF_IRQ_STAT, 32'h0000_0002);
		chk(32'(irq), 32'h0000_0000);
		// A bad frame breaks the pair, so one more good frame is not enough
		frame(1);
		frame(0);
		frame(1);
		settle(2);
		rd(`TLS_OFF_STATUS, 32'h0000_001C);
		chk(32'(n_dlv), 32'h0000_0001);
		md.link_pulse_ok <= 1;
		settle(4);
		md.link_pulse_ok <= 0;
		rd(`TLS_OFF_STATUS, 32'h0000_0018);
		$display("link loss and pulse test done");
		md.rx_data <= 1;
		settle(5);
		chk(32'(rx_data), 32'h0000_0001);
		md.pol_neg <= 1;
		settle(5);
		rd(`TLS_OFF_STATUS, 32'h0000_0010);
		chk(32'(rx_data), 32'h0000_0000);
		wr(`TLS_OFF_CTRL, 32'h0000_4102);
		settle(2);
		chk(32'(rx_data), 32'h0000_0001);
		wr(`TLS_OFF_CTRL, 32'h0000_0102);
		settle(2);
		chk(32'(rx_data), 32'h0000_0000);
		md.pol_neg <= 0;
		$display("polarity test done");
		wr(`TLS_OFF_IRQ_STAT, 32'h0000_0007);
		md.aui_act <= 1;
		settle(4);
		wr(`TLS_OFF_STATUS, 32'h0000_0100);
		rd(`TLS_OFF_STATUS, 32'h0000_0118);
		md.aui_act <= 0;
		settle(4);
		wr(`TLS_OFF_STATUS, 32'h0000_0100);
		rd(`TLS_OFF_STATUS, 32'h0000_0018);
		rd(`TLS_OFF_IRQ_STAT, 32'h0000_0001);
		$display("activity flag test done");
		an_arb_state <= 3'h3;
		wr(`TLS_OFF_CTRL, 32'h0000_2182);
		rd(`TLS_OFF_STATUS, 32'h0000_3008);
		an_arb_state <= 3'h5;
		rd(`TLS_OFF_STATUS, 32'h0000_5018);
		wr(`TLS_OFF_CTRL, 32'h0000_2183);
		rd(`TLS_OFF_STATUS, 32'h0000_5008);
		an_arb_state <= 3'h0;
		wr(`TLS_OFF_CTRL, 32'h0000_2002);
		rd(`TLS_OFF_STATUS, 32'h0000_0008);
		rd(4'h2, 32'h0000_0000, 2'h2);
		wr(4'h6, 32'h0000_2183, 2'h2);
		rd(`TLS_OFF_CTRL, 32'h0000_2002);
		$display("validity and refusal test done");
		print_verdict();
	end
endmodule : tls_link_status_bench
